// File: tcp_top.sv
// timer control, zero-detect status and port c data path behind a wishbone slave
`timescale 1ns/1ps
`include "tcp_map.svh"
module tcp_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    input wire logic [7:0] pcIn,
    output logic [7:0] pcOut,
    output logic [7:0] pcOeN,
    output logic [7:0] vecData,
    output logic vecValid
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    tcp_pkg::tcp_state_t state_reg, state_next;
    logic [7:0] pinSync;
    logic [1:0] pinFn;
    logic [1:0] clkMode;
    logic run;
    logic tinRise;
    logic ackAsserted;
    logic busHit;
    logic busWrite;
    logic busRead;
    logic clearFlag;
    logic [7:0] adrWord;
    logic [7:0] portRead;
    logic [31:0] readMux;
    logic [7:0] altPins;
    tcp_count_if cntIf ();

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // pins taken from port c by the timer for a given control value
    function automatic logic [7:0] altMask(input logic [7:0] ctrl);
        logic [7:0] m;
        m = 8'h00;
        m[`TCP_PIN_OUT] = (ctrl[`TCP_FLD_PIN] != `TCP_FN_PORT);
        m[`TCP_PIN_ACK] = (ctrl[`TCP_FLD_PIN] == `TCP_FN_VEC);
        m[`TCP_PIN_TIN] = (ctrl[`TCP_FLD_CLK] != `TCP_CLK_SYS);
        return m;
    endfunction : altMask

    ////////////////////////////////////////////////////////////////////////////
    // submodules

    // every pin passes two flops before use
    tcp_sync #(
        .W(8)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .d(pcIn),
        .q(pinSync)
    );

    // prescaler and counter
    tcp_count u_count (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .cnt(cntIf)
    );

    // controls toward the counter core
    assign cntIf.run = run;
    assign cntIf.clkMode = clkMode;
    assign cntIf.rollover = state_reg.ctrl[`TCP_BIT_ROLL];
    assign cntIf.preload = state_reg.preload;
    assign cntIf.tinRise = tinRise;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // control fields, run state and bus strobes
    always_comb begin
        pinFn = state_reg.ctrl[`TCP_FLD_PIN];
        clkMode = state_reg.ctrl[`TCP_FLD_CLK];
        run = state_reg.ctrl[`TCP_BIT_EN]
            && (clkMode != `TCP_CLK_GATE || pinSync[`TCP_PIN_TIN]);
        tinRise = pinSync[`TCP_PIN_TIN] && !state_reg.tinPrev;
        ackAsserted = !pinSync[`TCP_PIN_ACK];
        busHit = wbCyc && wbStb && state_reg.bus == tcp_pkg::BUS_IDLE;
        busWrite = busHit && wbWe;
        busRead = busHit && !wbWe;
        adrWord = {wbAdr[7:2], 2'b00};
        clearFlag = busWrite && adrWord == `TCP_OFS_STAT && wbSel[0] && wbDatI[0];
        portRead = (pinSync & ~state_reg.dir) | (state_reg.latch & state_reg.dir);
        altPins = altMask(state_reg.ctrl);
    end

    // read data selection; unmapped words read zero
    always_comb begin
        readMux = 32'h00000000;
        unique case (adrWord)
            `TCP_OFS_CTRL: readMux[7:0] = state_reg.ctrl;
            `TCP_OFS_PCDATA: readMux[7:0] = portRead;
            `TCP_OFS_PCDIR: readMux[7:0] = state_reg.dir;
            `TCP_OFS_STAT: readMux[0] = state_reg.flag;
            `TCP_OFS_VEC: readMux[7:0] = state_reg.vec;
            `TCP_OFS_PRE: readMux[23:0] = state_reg.preload;
            `TCP_OFS_CNT: readMux[23:0] = cntIf.count;
            default: readMux = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_next = state_reg;
        state_next.tinPrev = pinSync[`TCP_PIN_TIN];

        // single-cycle answer to every request
        unique case (state_reg.bus)
            tcp_pkg::BUS_IDLE: begin
                if (busHit) begin
                    state_next.bus = tcp_pkg::BUS_ACK;
                end
            end
            tcp_pkg::BUS_ACK: begin
                state_next.bus = tcp_pkg::BUS_IDLE;
            end
        endcase
        if (busRead) begin
            state_next.rdata = readMux;
        end

        // register writes by byte lane
        if (busWrite) begin
            unique case (adrWord)
                `TCP_OFS_CTRL: begin
                    if (wbSel[0]) begin
                        state_next.ctrl = wbDatI[7:0] & `TCP_CTRL_WMASK;
                    end
                end
                `TCP_OFS_PCDATA: begin
                    if (wbSel[0]) begin
                        state_next.latch = wbDatI[7:0];
                    end
                end
                `TCP_OFS_PCDIR: begin
                    if (wbSel[0]) begin
                        state_next.dir = wbDatI[7:0];
                    end
                end
                `TCP_OFS_VEC: begin
                    if (wbSel[0]) begin
                        state_next.vec = wbDatI[7:0];
                    end
                end
                `TCP_OFS_PRE: begin
                    if (wbSel[0]) begin
                        state_next.preload[7:0] = wbDatI[7:0];
                    end
                    if (wbSel[1]) begin
                        state_next.preload[15:8] = wbDatI[15:8];
                    end
                    if (wbSel[2]) begin
                        state_next.preload[23:16] = wbDatI[23:16];
                    end
                end
                default: begin
                    state_next.rdata = state_reg.rdata;
                end
            endcase
        end

        // zero-detect flag; any clear beats a set
        if (!run || clearFlag) begin
            state_next.flag = 1'b0;
        end else if (cntIf.zeroHit) begin
            state_next.flag = 1'b1;
        end

        // square wave level, high while halted
        if (!run) begin
            state_next.square = 1'b1;
        end else if (cntIf.zeroHit) begin
            state_next.square = !state_reg.square;
        end

        // port pins: drive outputs still in port function, plus pin 3 for the square wave or a low request
        state_next.pinOut = state_reg.latch;
        state_next.pinOeN = ~(state_reg.dir & ~altPins);
        if (pinFn == `TCP_FN_SQR) begin
            state_next.pinOut[`TCP_PIN_OUT] = state_reg.square;
            state_next.pinOeN[`TCP_PIN_OUT] = 1'b0;
        end else if (pinFn[1]) begin
            state_next.pinOut[`TCP_PIN_OUT] = 1'b0;
            state_next.pinOeN[`TCP_PIN_OUT] =
                !(state_reg.ctrl[`TCP_BIT_IRQ] && state_reg.flag);
        end

        // vector answer to an acknowledge in vectored mode
        state_next.vecValid = pinFn == `TCP_FN_VEC
            && state_reg.ctrl[`TCP_BIT_IRQ] && ackAsserted;
        state_next.vecData = state_next.vecValid ? state_reg.vec : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // port latch and preload keep their contents through reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg.bus <= tcp_pkg::BUS_IDLE;
            state_reg.rdata <= 32'h00000000;
            state_reg.ctrl <= `TCP_RST_CTRL;
            state_reg.dir <= `TCP_RST_DIR;
            state_reg.vec <= `TCP_RST_VEC;
            state_reg.flag <= 1'b0;
            state_reg.square <= 1'b1;
            state_reg.tinPrev <= 1'b0;
            state_reg.pinOut <= `TCP_RST_PINOUT;
            state_reg.pinOeN <= `TCP_RST_OEN;
            state_reg.vecData <= 8'h00;
            state_reg.vecValid <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign wbAck = state_reg.bus;
    assign wbDatO = state_reg.rdata;
    assign pcOut = state_reg.pinOut;
    assign pcOeN = state_reg.pinOeN;
    assign vecData = state_reg.vecData;
    assign vecValid = state_reg.vecValid;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_request;
        ce && wbCyc && wbStb && !wbAck;
    endsequence

    sequence s_halted_square;
        ce && !run && pinFn == `TCP_FN_SQR ##1 ce && pinFn == `TCP_FN_SQR;
    endsequence

    // own clock and no disable, so the edge that ends reset is still watched
    a_ctrl_reset: assert property (@(posedge clock) disable iff (1'b0)
        $rose(resetn) |-> state_reg.ctrl == 8'h00)
        else $error("control not cleared by reset");

    a_bit3_zero: assert property (s_request and wbWe && adrWord == `TCP_OFS_CTRL
        |=> state_reg.ctrl[3] == 1'b0)
        else $error("control bit 3 took a write");

    a_bus_answer: assert property (s_request |=> wbAck ##1 !wbAck)
        else $error("request not answered in one cycle");

    a_port_pins: assert property (ce && pinFn == `TCP_FN_PORT
        |=> pcOeN[`TCP_PIN_OUT] == !$past(state_reg.dir[`TCP_PIN_OUT])
        && pcOut[`TCP_PIN_OUT] == $past(state_reg.latch[`TCP_PIN_OUT]))
        else $error("port function pin three misdriven");

    a_alt_undriven: assert property (ce |=> (~pcOeN & $past(altMask(state_reg.ctrl))
        & 8'h84) == 8'h00)
        else $error("alternate input pin driven");

    a_square_halt: assert property (s_halted_square
        |=> pcOut[`TCP_PIN_OUT] && !pcOeN[`TCP_PIN_OUT])
        else $error("square output not high while halted");

    a_request_low: assert property (ce && pinFn[1] && state_reg.ctrl[`TCP_BIT_IRQ]
        && state_reg.flag |=> !pcOeN[`TCP_PIN_OUT] && !pcOut[`TCP_PIN_OUT])
        else $error("request pin not low with flag set");

    a_request_off: assert property (ce && pinFn[1] && !state_reg.ctrl[`TCP_BIT_IRQ]
        |=> pcOeN[`TCP_PIN_OUT] && !vecValid)
        else $error("disabled request pin driven");

    a_port_read: assert property (s_request and !wbWe && adrWord == `TCP_OFS_PCDATA
        |=> wbAck && wbDatO[7:0] == $past(portRead))
        else $error("port c read data wrong");

    a_latch_write: assert property (s_request and wbWe && wbSel[0]
        && adrWord == `TCP_OFS_PCDATA |=> state_reg.latch == $past(wbDatI[7:0]))
        else $error("port c latch not written");

    a_clear_wins: assert property (ce && (!run || clearFlag) |=> !state_reg.flag)
        else $error("flag survived a clear");

    a_flag_set: assert property (ce && run && !clearFlag && cntIf.zeroHit
        |=> state_reg.flag)
        else $error("zero detect did not set flag");

    a_vector_out: assert property (ce && pinFn == `TCP_FN_VEC
        && state_reg.ctrl[`TCP_BIT_IRQ] && ackAsserted
        |=> vecValid && vecData == $past(state_reg.vec))
        else $error("vector not supplied on acknowledge");

endmodule : tcp_top

// File: tcp_map.svh
// register offsets, field positions, reset values and codes of the timer block
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
`define TCP_OFS_CTRL 8'h00
`define TCP_OFS_PCDATA 8'h04
`define TCP_OFS_PCDIR 8'h08
`define TCP_OFS_STAT 8'h0c
`define TCP_OFS_VEC 8'h10
`define TCP_OFS_PRE 8'h14
`define TCP_OFS_CNT 8'h18
`define TCP_BIT_EN 0
`define TCP_BIT_ROLL 4
`define TCP_BIT_IRQ 5
`define TCP_FLD_CLK 2:1
`define TCP_FLD_PIN 7:6
`define TCP_RST_CTRL 8'h00
`define TCP_RST_VEC 8'h0f
`define TCP_RST_DIR 8'h00
`define TCP_RST_PINOUT 8'h00
`define TCP_RST_OEN 8'hff
`define TCP_RST_CNT 24'h000000
`define TCP_CTRL_WMASK 8'hf7
`define TCP_PRE_MAX 5'h1f
`define TCP_PIN_TIN 2
`define TCP_PIN_OUT 3
`define TCP_PIN_ACK 7
`define TCP_CLK_SYS 2'h0
`define TCP_CLK_GATE 2'h1
`define TCP_CLK_PRE 2'h2
`define TCP_CLK_DIR 2'h3
`define TCP_FN_PORT 2'h0
`define TCP_FN_SQR 2'h1
`define TCP_FN_VEC 2'h2
`define TCP_FN_AUTO 2'h3
`endif

// File: tcp_pkg.sv
// types shared by the timer block modules
package tcp_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} tcp_bus_t;
    typedef struct packed {
        tcp_bus_t bus;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] vec;
        logic [23:0] preload;
        logic flag;
        logic square;
        logic tinPrev;
        logic [7:0] pinOut;
        logic [7:0] pinOeN;
        logic [7:0] vecData;
        logic vecValid;
    } tcp_state_t;
    typedef struct packed {
        logic [4:0] pre;
        logic [23:0] count;
        logic zeroHit;
    } tcp_cnt_t;
endpackage : tcp_pkg

// File: tcp_count_if.sv
// signals between the control logic and the counter core
`timescale 1ns/1ps
interface tcp_count_if;
    logic run;
    logic [1:0] clkMode;
    logic rollover;
    logic [23:0] preload;
    logic tinRise;
    logic [23:0] count;
    logic zeroHit;
    modport ctl (output run, clkMode, rollover, preload, tinRise, input count, zeroHit);
    modport core (input run, clkMode, rollover, preload, tinRise, output count, zeroHit);
endinterface : tcp_count_if

// File: tcp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tcp_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tcp_sync_t;
    tcp_sync_t state_reg, state_next;

    // first stage feeds only the second
    always_comb begin
        state_next.s1 = d;
        state_next.s2 = state_reg.s1;
    end

    // register the stages
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.s2;
endmodule : tcp_sync

// File: tcp_count.sv
// prescaler and 24-bit down counter with reload or roll over
`timescale 1ns/1ps
`include "tcp_map.svh"
module tcp_count (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    tcp_count_if.core cnt
);
    tcp_pkg::tcp_cnt_t state_reg, state_next;
    logic tick;
    logic stepPre;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // prescaler and counter stepping; nothing moves while halted
    always_comb begin
        state_next = state_reg;
        state_next.zeroHit = 1'b0;
        tick = 1'b0;
        stepPre = 1'b0;
        if (cnt.run) begin
            if (cnt.clkMode == `TCP_CLK_DIR) begin
                tick = cnt.tinRise;
            end else if (cnt.clkMode == `TCP_CLK_PRE) begin
                stepPre = cnt.tinRise;
            end else begin
                stepPre = 1'b1;
            end
            if (stepPre) begin
                state_next.pre = state_reg.pre - 5'h01;
                tick = (state_reg.pre == 5'h00);
            end
            if (tick) begin
                if (state_reg.count == 24'h000000 && !cnt.rollover) begin
                    state_next.count = cnt.preload;
                end else begin
                    state_next.count = state_reg.count - 24'h000001;
                end
                state_next.zeroHit = (state_reg.count == 24'h000001);
            end
        end
    end

    // register the counter state
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg.pre <= `TCP_PRE_MAX;
            state_reg.count <= `TCP_RST_CNT;
            state_reg.zeroHit <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign cnt.count = state_reg.count;
    assign cnt.zeroHit = state_reg.zeroHit;

    a_halt_hold: assert property (ce && !cnt.run
        |=> $stable(state_reg.pre) && $stable(state_reg.count))
        else $error("counter moved while halted");
    a_pre_wrap: assert property (ce && tick && stepPre |=> state_reg.pre == `TCP_PRE_MAX)
        else $error("prescaler did not wrap to max");
    a_reload_zero: assert property (ce && tick && state_reg.count == 24'h000000
        && !cnt.rollover |=> state_reg.count == $past(cnt.preload))
        else $error("counter not reloaded after zero");
    a_direct_step: assert property (ce && cnt.run && cnt.clkMode == `TCP_CLK_DIR
        && cnt.tinRise && state_reg.count != 24'h000000
        |=> state_reg.count == $past(state_reg.count) - 24'h000001)
        else $error("direct edge did not step counter");
endmodule : tcp_count

// File: tcp_pin_model.sv
// port c pin model: each pin level from the block's drive, an outside driver or a pull-up
`timescale 1ns/1ps
module tcp_pin_model (
    input wire logic [7:0] pcOut,
    input wire logic [7:0] pcOeN,
    input wire logic [7:0] extEn,
    input wire logic [7:0] extVal,
    output logic [7:0] pinLvl
);
    // block drive wins, then the outside driver, else the pull-up holds the pin high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinLvl[i] = !pcOeN[i] ? pcOut[i] : (extEn[i] ? extVal[i] : 1'b1);
        end
    end
endmodule : tcp_pin_model

// File: timer_control_and_port_c_tb.sv
// self-checking bench for the timer control and port c block
`timescale 1ns/1ps
`include "tcp_map.svh"
module timer_control_and_port_c_tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [31:0] wbDatO;
    logic wbAck;
    logic [7:0] pcIn, pcOut, pcOeN, vecData, extEn = 8'h00, extVal = 8'h00;
    logic vecValid;
    logic [31:0] rd;
    int miscompares = 0;
    int samplesChecked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and pins
    always #4 clock = ~clock;
    tcp_top u_dut (.clock(clock), .resetn(resetn), .ce(1'b1), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
        .wbAck(wbAck), .pcIn(pcIn), .pcOut(pcOut), .pcOeN(pcOeN), .vecData(vecData),
        .vecValid(vecValid));
    tcp_pin_model u_pins (.pcOut(pcOut), .pcOeN(pcOeN), .extEn(extEn), .extVal(extVal),
        .pinLvl(pcIn));
    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", miscompares, samplesChecked);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
    endtask : waitc
    // one classic wishbone cycle; held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDatI <= dat;
        @(posedge clock);
        while (wbAck !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        // a request that never got its answer counts against the run
        if (wbAck !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: ack %h expected %h", $time, wbAck, 1'b1);
        end
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        wbSel <= 4'h0;
        @(posedge clock);
    endtask : bus
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic do_reset;
        resetn <= 1'b0;
        waitc(10);
        resetn <= 1'b1;
        waitc(1);
    endtask : do_reset
    // pulses on the timer input pin, long enough for the synchroniser
    task automatic tin_edges(input int n);
        repeat (n) begin
            extVal[2] <= 1'b1;
            waitc(4);
            extVal[2] <= 1'b0;
            waitc(4);
        end
    endtask : tin_edges
    task automatic wait_flag;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 300) begin
            bus(1'b0, `TCP_OFS_STAT, 32'h0);
            n++;
        end
        chk(rd, 32'h1);
    endtask : wait_flag
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        chk({24'h0, pcOeN}, 32'hff);
        rdchk(`TCP_OFS_CTRL, 32'h00);
        rdchk(`TCP_OFS_VEC, 32'h0f);
        bus(1'b1, `TCP_OFS_CTRL, 32'hff);
        rdchk(`TCP_OFS_CTRL, 32'hf7);
        rdchk(8'hfc, 32'h0);
        bus(1'b1, `TCP_OFS_CTRL, 32'h00);
    endtask : t_regs
    task automatic t_port;
        bus(1'b1, `TCP_OFS_PCDIR, 32'h0f);
        bus(1'b1, `TCP_OFS_PCDATA, 32'ha5);
        extEn <= 8'hf0;
        extVal <= 8'h30;
        waitc(3);
        chk({24'h0, pcOeN}, 32'hf0);
        chk({28'h0, pcOut[3:0]}, 32'h5);
        rdchk(`TCP_OFS_PCDATA, 32'h35);
        extEn <= 8'h00;
        do_reset();
        bus(1'b1, `TCP_OFS_PCDIR, 32'hff);
        rdchk(`TCP_OFS_PCDATA, 32'ha5);
    endtask : t_port
    task automatic t_vec;
        logic [31:0] c;
        do_reset();
        bus(1'b1, `TCP_OFS_PRE, 32'h2);
        bus(1'b1, `TCP_OFS_CTRL, 32'ha1);
        wait_flag();
        chk({30'h0, pcOeN[3], pcOut[3]}, 32'h0);
        extEn <= 8'h80;
        waitc(4);
        chk({23'h0, vecValid, vecData}, 32'h10f);
        extEn <= 8'h00;
        bus(1'b1, `TCP_OFS_STAT, 32'h1);
        rdchk(`TCP_OFS_STAT, 32'h0);
        chk({31'h0, pcOeN[3]}, 32'h1);
        wait_flag();
        bus(1'b1, `TCP_OFS_CTRL, 32'ha0);
        rdchk(`TCP_OFS_STAT, 32'h0);
        bus(1'b0, `TCP_OFS_CNT, 32'h0);
        c = rd;
        waitc(70);
        rdchk(`TCP_OFS_CNT, c);
    endtask : t_vec
    task automatic t_pinfn;
        logic [7:0] ctl [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
        logic [3:0] oen = 4'b1100;
        logic [3:0] lvl = 4'b0010;
        do_reset();
        bus(1'b1, `TCP_OFS_PCDIR, 32'h08);
        bus(1'b1, `TCP_OFS_PCDATA, 32'h00);
        extEn <= 8'h80;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TCP_OFS_CTRL, {24'h0, ctl[i]});
            waitc(4);
            chk({31'h0, pcOeN[3]}, {31'h0, oen[i]});
            if (!oen[i]) chk({31'h0, pcOut[3]}, {31'h0, lvl[i]});
            chk({31'h0, vecValid}, 32'h0);
        end
        extEn <= 8'h00;
    endtask : t_pinfn
    task automatic t_ext;
        do_reset();
        extEn <= 8'h04;
        bus(1'b1, `TCP_OFS_PRE, 32'h3);
        bus(1'b1, `TCP_OFS_CTRL, 32'h07);
        tin_edges(3);
        rdchk(`TCP_OFS_STAT, 32'h0);
        rdchk(`TCP_OFS_CNT, 32'h1);
        tin_edges(1);
        rdchk(`TCP_OFS_STAT, 32'h1);
        bus(1'b1, `TCP_OFS_CTRL, 32'h17);
        tin_edges(1);
        rdchk(`TCP_OFS_CNT, 32'hffffff);
    endtask : t_ext
    task automatic t_gate;
        do_reset();
        bus(1'b1, `TCP_OFS_PRE, 32'h5);
        bus(1'b1, `TCP_OFS_CTRL, 32'h03);
        waitc(80);
        rdchk(`TCP_OFS_CNT, 32'h0);
        extEn <= 8'h00;
        waitc(20);
        rdchk(`TCP_OFS_CNT, 32'h0);
        waitc(20);
        rdchk(`TCP_OFS_CNT, 32'h5);
        extEn <= 8'h04;
        // restart from a full prescaler; preload keeps 5 through reset
        do_reset();
        bus(1'b1, `TCP_OFS_CTRL, 32'h05);
        tin_edges(20);
        rdchk(`TCP_OFS_CNT, 32'h0);
        tin_edges(20);
        rdchk(`TCP_OFS_CNT, 32'h5);
    endtask : t_gate
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        do_reset();
        t_regs();
        t_port();
        t_vec();
        t_pinfn();
        t_ext();
        t_gate();
        end_sim();
    end
    initial begin
        #400000;
        miscompares++;
        end_sim();
    end
endmodule : timer_control_and_port_c_tb
